// *** aisr_chan_decode.sv ***
// Registered decoder from channel code to input routing and gain
`timescale 1ns/1ps
module aisr_chan_decode (
  // Clock, reset, enable
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  // Channel code in, routing out
  input  wire logic [4:0]           chan_sel_i,
  output aisr_pkg::aisr_route_t     route_o
);

  aisr_pkg::aisr_route_t route_ff;
  aisr_pkg::aisr_route_t nxt_route;

  assign route_o = route_ff;

  //////////////////////////////////////////////////////////////////////////////
  // channel code map
  always_comb begin
    nxt_route           = '0;
    nxt_route.gain      = aisr_pkg::GAIN_1X;
    nxt_route.pos_input = chan_sel_i[2:0];
    if (chan_sel_i <= aisr_pkg::CHAN_SE_LAST) begin
      nxt_route.diff = 1'b0;
    end else if (chan_sel_i < aisr_pkg::CHAN_DIFF_HI) begin
      nxt_route.diff      = 1'b1;
      nxt_route.gain      = chan_sel_i[1] ? aisr_pkg::GAIN_200X : aisr_pkg::GAIN_10X;
      nxt_route.pos_input = {1'b0, chan_sel_i[2], chan_sel_i[0]};
      nxt_route.neg_input = {1'b0, chan_sel_i[2], 1'b0};
    end else if (chan_sel_i <= aisr_pkg::CHAN_DIFF_LAST) begin
      nxt_route.diff      = 1'b1;
      nxt_route.neg_input = chan_sel_i[3] ? aisr_pkg::NEG_INPUT_2 : aisr_pkg::NEG_INPUT_1;
    end else if (chan_sel_i == aisr_pkg::CHAN_BANDGAP) begin
      nxt_route.bandgap   = 1'b1;
      nxt_route.pos_input = 3'h0;
    end else begin
      nxt_route.ground    = 1'b1;
      nxt_route.pos_input = 3'h0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      route_ff <= '0;
    end else if (ce_i) begin
      route_ff <= nxt_route;
    end
  end

endmodule : aisr_chan_decode

// *** aisr_pkg.sv ***
// Package: register map, field layout and types of the input select block
package aisr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RESULT_LOW  = 8'h78;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
  localparam logic [7:0] IDX_CTRL_STAT_A = 8'h7A;
  localparam logic [7:0] IDX_INPUT_SEL   = 8'h7C;
  localparam int         ADDR_W          = 10;
  localparam logic [1:0] ADDR_LSB_ZERO   = 2'h0;

  // Reset values
  localparam logic [7:0] INPUT_SEL_RST   = 8'h00;
  localparam logic [9:0] RESULT_RST      = 10'h000;

  // Field positions in input_reference_select
  localparam int REF_SEL_HI  = 7;
  localparam int REF_SEL_LO  = 6;
  localparam int LEFT_ADJ    = 5;
  localparam int CHAN_SEL_HI = 4;
  localparam int CHAN_SEL_LO = 0;

  // Field positions in converter_control_status_a
  localparam int CSA_START   = 6;
  localparam int CSA_DONE    = 4;

  // Result alignment
  localparam int RES_W       = 10;
  localparam int PAD_W       = 6;

  // Channel code landmarks
  localparam logic [4:0] CHAN_SE_LAST   = 5'h07;
  localparam logic [4:0] CHAN_DIFF_HI   = 5'h10;
  localparam logic [4:0] CHAN_DIFF_LAST = 5'h1D;
  localparam logic [4:0] CHAN_BANDGAP   = 5'h1E;
  localparam logic [4:0] CHAN_GROUND    = 5'h1F;
  localparam logic [2:0] NEG_INPUT_1    = 3'h1;
  localparam logic [2:0] NEG_INPUT_2    = 3'h2;

  // Reference sources
  typedef enum logic [1:0] {
    REF_PIN      = 2'h0,
    REF_SUPPLY   = 2'h1,
    REF_INT_1V1  = 2'h2,
    REF_INT_2V56 = 2'h3
  } aisr_ref_t;

  // Gain settings
  typedef enum logic [1:0] {
    GAIN_1X   = 2'h0,
    GAIN_10X  = 2'h1,
    GAIN_200X = 2'h2
  } aisr_gain_t;

  // Input selection register image
  typedef struct packed {
    aisr_ref_t  ref_sel;
    logic       left_adj;
    logic [4:0] chan_sel;
  } aisr_sel_t;

  // Decoded routing of a channel code
  typedef struct packed {
    logic       diff;
    logic       bandgap;
    logic       ground;
    aisr_gain_t gain;
    logic [2:0] pos_input;
    logic [2:0] neg_input;
  } aisr_route_t;

endpackage : aisr_pkg

// *** aisr_top.sv ***
// Converter input selection, deferred apply, result capture and formatting
//
// Functional notes
// - Result register loads only when conversion done flag gets set.
// - Single-ended result is an unsigned 10-bit code, 0x000 to 0x3FF.
// - Differential result is 10-bit two's complement, -512 to +511.
// - Top result bit is the sign for differential results.
// - Left adjust bit one gives left aligned, zero right aligned result.
// - Left adjust change realigns the result at once, even mid-conversion.
// - Reference select written mid-conversion applies only after it completes.
// - Channel and gain select written mid-conversion applies only after completion.
// - Reference codes: pin, analog supply, internal 1.1 V, internal 2.56 V.
// - Codes 0-7 single-ended, 0x1E bandgap, 0x1F ground, rest differential.
// - Codes 0x08-0x0F give 10x or 200x, 0x10-0x1D give unity gain.
// - Left aligned uses bits 15..6, right aligned 9..0, others zero.
// - After a low byte read, result holds until the high byte is read.
`timescale 1ns/1ps
module aisr_top (
  // Clock, reset, enable
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // Avalon-MM register slave
  input  wire logic [aisr_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic      [31:0]              avs_readdata_o,
  output logic                          avs_waitrequest_o,
  // Converter core
  output logic                          conv_start_o,
  input  wire logic                     conv_done_i,
  input  wire logic [9:0]               conv_data_i,
  // Applied analog selection and busy status
  output aisr_pkg::aisr_ref_t           ref_sel_o,
  output aisr_pkg::aisr_route_t         route_o,
  output logic                          busy_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  aisr_pkg::aisr_sel_t   sel_ff;
  aisr_pkg::aisr_sel_t   applied_ff;
  aisr_pkg::aisr_route_t route_w;
  aisr_pkg::aisr_ref_t   ref_ff;

  logic [31:0]                 readdata_ff;
  logic [31:0]                 nxt_readdata;
  logic                        waitreq_ff;
  logic                        start_ff;
  logic                        busy_ff;
  logic                        done_ff;
  logic                        lock_ff;
  logic [aisr_pkg::RES_W-1:0]  result_ff;
  logic [aisr_pkg::RES_W-1:0]  nxt_code;
  logic [15:0]                 fmt_result;
  logic                        req;
  logic                        accept;
  logic                        wr_acc;
  logic                        rd_acc;
  logic [7:0]                  word_idx;
  logic                        addr_aligned;
  logic                        hit_sel;
  logic                        hit_csa;
  logic                        hit_low;
  logic                        hit_high;
  logic                        wr_sel;
  logic                        wr_start;
  logic                        wr_done_clr;
  logic                        rd_low;
  logic                        rd_high;

  //////////////////////////////////////////////////////////////////////////////
  // Output drive

  assign avs_readdata_o    = readdata_ff;
  assign avs_waitrequest_o = waitreq_ff;
  assign conv_start_o      = start_ff;
  assign busy_o            = busy_ff;
  assign ref_sel_o         = ref_ff;
  assign route_o           = route_w;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign req          = avs_read_i | avs_write_i;
  assign accept       = req & waitreq_ff;
  assign wr_acc       = accept & avs_write_i;
  assign rd_acc       = accept & avs_read_i & ~avs_write_i;
  assign word_idx     = avs_address_i[9:2];
  assign addr_aligned = (avs_address_i[1:0] == aisr_pkg::ADDR_LSB_ZERO);

  assign hit_sel  = addr_aligned & (word_idx == aisr_pkg::IDX_INPUT_SEL);
  assign hit_csa  = addr_aligned & (word_idx == aisr_pkg::IDX_CTRL_STAT_A);
  assign hit_low  = addr_aligned & (word_idx == aisr_pkg::IDX_RESULT_LOW);
  assign hit_high = addr_aligned & (word_idx == aisr_pkg::IDX_RESULT_HIGH);

  assign wr_sel      = wr_acc & hit_sel & avs_byteenable_i[0];
  assign wr_start    = wr_acc & hit_csa & avs_byteenable_i[0]
                       & avs_writedata_i[aisr_pkg::CSA_START];
  assign wr_done_clr = wr_acc & hit_csa & avs_byteenable_i[0]
                       & avs_writedata_i[aisr_pkg::CSA_DONE];
  assign rd_low      = rd_acc & hit_low;
  assign rd_high     = rd_acc & hit_high;

  //////////////////////////////////////////////////////////////////////////////
  // Wait request: one wait cycle, then one cycle low per access

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      waitreq_ff <= 1'b1;
    end else if (ce_i) begin
      waitreq_ff <= ~accept;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result formatting

  // choose alignment from live left adjust bit
  // live bit realigns stored result at once
  always_comb begin
    if (sel_ff.left_adj) begin
      fmt_result = {result_ff, {aisr_pkg::PAD_W{1'b0}}};
    end else begin
      fmt_result = {{aisr_pkg::PAD_W{1'b0}}, result_ff};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    nxt_readdata = readdata_ff;
    if (rd_acc) begin
      nxt_readdata = 32'h0000_0000;
      if (hit_sel) begin
        nxt_readdata[7:0] = sel_ff;
      end else if (hit_csa) begin
        nxt_readdata[aisr_pkg::CSA_START] = busy_ff;
        nxt_readdata[aisr_pkg::CSA_DONE]  = done_ff;
      end else if (hit_low) begin
        nxt_readdata[7:0] = fmt_result[7:0];
      end else if (hit_high) begin
        // sign bit lands in top result bit
        nxt_readdata[7:0] = fmt_result[15:8];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      readdata_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      readdata_ff <= nxt_readdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Selection register, software image

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sel_ff <= aisr_pkg::INPUT_SEL_RST;
    end else if (ce_i && wr_sel) begin
      sel_ff <= aisr_pkg::aisr_sel_t'(avs_writedata_i[7:0]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Applied selection, frozen during a conversion

  // channel and gain deferred while busy
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      applied_ff <= aisr_pkg::INPUT_SEL_RST;
    end else if (ce_i) begin
      if (!busy_ff || conv_done_i) begin
        applied_ff <= wr_sel ? aisr_pkg::aisr_sel_t'(avs_writedata_i[7:0]) : sel_ff;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ref_ff <= aisr_pkg::REF_PIN;
    end else if (ce_i) begin
      ref_ff <= applied_ff.ref_sel;
    end
  end

  aisr_chan_decode u_decode (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .chan_sel_i (applied_ff.chan_sel),
    .route_o    (route_w)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Conversion start and busy

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      start_ff <= 1'b0;
    end else if (ce_i) begin
      start_ff <= wr_start & ~busy_ff;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
    end else if (ce_i) begin
      if (wr_start && !busy_ff) begin
        busy_ff <= 1'b1;
      end else if (conv_done_i) begin
        busy_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion done flag, write one to clear, set wins

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
    end else if (ce_i) begin
      if (busy_ff && conv_done_i) begin
        done_ff <= 1'b1;
      end else if (wr_done_clr) begin
        done_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result capture

  // offset-binary differential code to two's complement
  always_comb begin
    if (route_w.diff) begin
      nxt_code = {~conv_data_i[9], conv_data_i[8:0]};
    end else begin
      nxt_code = conv_data_i;
    end
  end

  // low byte read locks until high byte read
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lock_ff <= 1'b0;
    end else if (ce_i) begin
      if (rd_high) begin
        lock_ff <= 1'b0;
      end else if (rd_low) begin
        lock_ff <= 1'b1;
      end
    end
  end

  // load result together with done flag
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      result_ff <= aisr_pkg::RESULT_RST;
    end else if (ce_i) begin
      if (busy_ff && conv_done_i && !lock_ff) begin
        result_ff <= nxt_code;
      end
    end
  end

endmodule : aisr_top

// *** aisr_top_monitor.sv ***
// Port-level assertions for the input select block
`timescale 1ns/1ps
module aisr_top_monitor (
  // Clock, reset, enable
  input wire logic                          clk_sys_i,
  input wire logic                          rst_i,
  input wire logic                          ce_i,
  // Register bus
  input wire logic [aisr_pkg::ADDR_W-1:0]   avs_address_i,
  input wire logic                          avs_read_i,
  input wire logic                          avs_write_i,
  input wire logic [31:0]                   avs_writedata_i,
  input wire logic [3:0]                    avs_byteenable_i,
  input wire logic [31:0]                   avs_readdata_o,
  input wire logic                          avs_waitrequest_o,
  // Converter and selection
  input wire logic                          conv_start_o,
  input wire logic                          conv_done_i,
  input wire logic [9:0]                    conv_data_i,
  input wire aisr_pkg::aisr_ref_t           ref_sel_o,
  input wire aisr_pkg::aisr_route_t         route_o,
  input wire logic                          busy_o
);
  ////////////////////////////////////////
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire logic mapped = avs_address_i[9:2] inside {aisr_pkg::IDX_RESULT_LOW,
    aisr_pkg::IDX_RESULT_HIGH, aisr_pkg::IDX_CTRL_STAT_A, aisr_pkg::IDX_INPUT_SEL} &&
    avs_address_i[1:0] == aisr_pkg::ADDR_LSB_ZERO;
  // Bus request taken, and start request accepted while idle
  sequence s_take;
    (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i;
  endsequence
  sequence s_start;
    s_take ##0 (avs_write_i && avs_address_i[9:2] == aisr_pkg::IDX_CTRL_STAT_A &&
      avs_byteenable_i[0] && avs_writedata_i[aisr_pkg::CSA_START] && !busy_o);
  endsequence
  ////////////////////////////////////////
  a_wait_one_cycle: assert property (s_take |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest not low for exactly one cycle");
  a_start_accepted: assert property (s_start |=> busy_o && conv_start_o ##1 !conv_start_o)
    else $error("start write did not give busy and one start pulse");
  a_no_restart: assert property (busy_o && !conv_done_i |=> !conv_start_o)
    else $error("start pulse while a conversion runs");
  a_done_ends_busy: assert property (busy_o && conv_done_i && ce_i |=> !busy_o)
    else $error("busy still high after done");
  a_ref_deferred: assert property (busy_o && !conv_done_i |=> $stable(ref_sel_o))
    else $error("reference changed mid-conversion");
  a_route_deferred: assert property (
    busy_o && $past(busy_o) && !conv_done_i |=> $stable(route_o))
    else $error("routing changed mid-conversion");
  a_unmapped_zero: assert property (s_take ##0 (avs_read_i && !mapped) |=> avs_readdata_o == 32'h0)
    else $error("unmapped read returned nonzero");
  a_ce_freeze: assert property (!ce_i |=> $stable(busy_o) && $stable(avs_waitrequest_o))
    else $error("state moved with clock enable low");
endmodule : aisr_top_monitor

bind aisr_top aisr_top_monitor aisr_top_monitor_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .conv_start_o(conv_start_o),
  .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .ref_sel_o(ref_sel_o),
  .route_o(route_o), .busy_o(busy_o));

// *** tb_aisr_top.sv ***
// Self-checking bench for the input select block
`timescale 1ns/1ps
module tb_aisr_top;
  localparam logic [9:0] A_LO  = {aisr_pkg::IDX_RESULT_LOW, aisr_pkg::ADDR_LSB_ZERO};
  localparam logic [9:0] A_HI  = {aisr_pkg::IDX_RESULT_HIGH, aisr_pkg::ADDR_LSB_ZERO};
  localparam logic [9:0] A_CS  = {aisr_pkg::IDX_CTRL_STAT_A, aisr_pkg::ADDR_LSB_ZERO};
  localparam logic [9:0] A_SEL = {aisr_pkg::IDX_INPUT_SEL, aisr_pkg::ADDR_LSB_ZERO};
  logic                  clk_sys_i, rst_i, ce_i, rd, wr, done, wait_o, start_o, busy;
  logic [9:0]            addr, cdata;
  logic [31:0]           wdata, rdata, q;
  logic [3:0]            be;
  aisr_pkg::aisr_ref_t   ref_sel;
  aisr_pkg::aisr_route_t route;
  int                    num_errors, tests_run;

  aisr_top aisr_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
    .conv_start_o(start_o), .conv_done_i(done), .conv_data_i(cdata),
    .ref_sel_o(ref_sel), .route_o(route), .busy_o(busy));
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys_i);
    rd    <= !w;
    wr    <= w;
    addr  <= a;
    wdata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wait_o !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_o !== 1'b0) begin
      num_errors++;
      give_verdict();
    end
  endtask : bus

  task automatic rdchk(input string nm, input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(nm, q, {24'h0, e});
  endtask : rdchk

  task automatic finish(input logic [9:0] d);
    @(posedge clk_sys_i);
    cdata <= d;
    done  <= 1'b1;
    @(posedge clk_sys_i);
    done  <= 1'b0;
  endtask : finish
  ////////////////////////////////////////
  task automatic t_reset();
    check("ref", 32'(ref_sel), 32'h0);
    check("route", 32'(route), 32'h0);
    rdchk("sel", A_SEL, 8'h00);
    rdchk("unmapped", 10'h1FC, 8'h00);
    rdchk("unaligned", 10'h1F1, 8'h00);
    be <= 4'h0;
    bus(1'b1, A_SEL, 8'hFF);
    be <= 4'hF;
    rdchk("sel", A_SEL, 8'h00);
  endtask : t_reset

  task automatic t_route();
    logic [15:0] tbl [8] = '{16'h3838, 16'h5480, 16'h7C9A, 16'h6C5A,
                             16'h8401, 16'hEC2A, 16'hF200, 16'hF900};
    logic [15:0] e;
    logic [1:0]  r;
    for (int k = 0; k < 8; k++) begin
      e = tbl[k];
      // differential pairs use 2.56 V or supply
      // other entries use reference code k[1:0]: pin, 1.1 V, 2.56 V
      r = e[10] ? (k[0] ? 2'h3 : 2'h1) : k[1:0];
      bus(1'b1, A_SEL, {r, 1'b0, e[15:11]});
      repeat (3) @(posedge clk_sys_i);
      check("ref", 32'(ref_sel), 32'(r));
      check("kind", 32'(route[10:6]), 32'(e[10:6]));
      if (!e[9] && !e[8]) check("pos", 32'(route[5:3]), 32'(e[5:3]));
      if (e[10]) check("neg", 32'(route[2:0]), 32'(e[2:0]));
    end
  endtask : t_route

  task automatic t_single();
    bus(1'b1, A_SEL, 8'h00);
    bus(1'b1, A_CS, 8'h40);
    finish(10'h3FF);
    rdchk("csa", A_CS, 8'h10);
    check("busy", 32'(busy), 32'h0);
    rdchk("lo", A_LO, 8'hFF);
    rdchk("hi", A_HI, 8'h03);
    bus(1'b1, A_CS, 8'h10);
    rdchk("csa", A_CS, 8'h00);
    bus(1'b1, A_CS, 8'h40);
    rdchk("csa", A_CS, 8'h40);
    check("busy", 32'(busy), 32'h1);
    rdchk("hi", A_HI, 8'h03);
    finish(10'h155);
    rdchk("lo", A_LO, 8'h55);
    bus(1'b1, A_CS, 8'h40);
    bus(1'b1, A_CS, 8'h40);
    @(posedge clk_sys_i) ce_i <= 1'b0;
    @(posedge clk_sys_i) ce_i <= 1'b1;
    finish(10'h2AA);
    rdchk("hi", A_HI, 8'h01);
    bus(1'b1, A_CS, 8'h40);
    finish(10'h0F0);
    rdchk("lo", A_LO, 8'hF0);
    rdchk("hi", A_HI, 8'h00);
  endtask : t_single

  task automatic t_diff();
    bus(1'b1, A_SEL, 8'hED);
    bus(1'b1, A_CS, 8'h40);
    finish(10'h070);
    rdchk("lo", A_LO, 8'h00);
    rdchk("hi", A_HI, 8'h9C);
    bus(1'b1, A_SEL, 8'hCD);
    rdchk("lo", A_LO, 8'h70);
    rdchk("hi", A_HI, 8'h02);
    bus(1'b1, A_CS, 8'h40);
    bus(1'b1, A_SEL, 8'hED);
    rdchk("hi", A_HI, 8'h9C);
    finish(10'h3FF);
    rdchk("lo", A_LO, 8'hC0);
    rdchk("hi", A_HI, 8'h7F);
  endtask : t_diff

  task automatic t_defer();
    bus(1'b1, A_CS, 8'h40);
    bus(1'b1, A_SEL, 8'h5F);
    repeat (3) @(posedge clk_sys_i);
    check("ref", 32'(ref_sel), 32'h3);
    check("route", 32'(route), 32'h45A);
    rdchk("sel", A_SEL, 8'h5F);
    finish(10'h000);
    repeat (3) @(posedge clk_sys_i);
    check("ref", 32'(ref_sel), 32'h1);
    check("gnd", 32'(route[10:8]), 32'h1);
  endtask : t_defer
  ////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    {rst_i, ce_i, rd, wr, done, addr, cdata, wdata, be} = {1'b1, 1'b1, 3'h0, 10'h0, 10'h0,
      32'h0, 4'hF};
    num_errors = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    t_route();
    t_single();
    t_diff();
    t_defer();
    give_verdict();
  end
endmodule : tb_aisr_top
